/* design/motor_pkg.sv */
// Constants and types shared by the motor drive logic
package motor_pkg;
    // Reference clock rate and tick pacing
    localparam int unsigned CLOCK_MHZ        = 250;
    // Target tachometer period in reference clocks
    localparam int unsigned SERVO_DIVIDE     = 8192;
    localparam logic [13:0] SERVO_COUNT      = 14'h2000;
    // Lock band: 6.25 percent of 8192 is 512
    localparam logic [13:0] LOCK_BAND        = 14'h0200;
    // Seconds per microfarad of timing capacitance
    localparam int unsigned SECONDS_PER_UF   = 52;
    // Lock timer prescale: one tick per microsecond
    localparam int unsigned TICK_NS          = 1000;
    localparam int unsigned CLOCK_NS         = 4;
    localparam int unsigned TICK_CYCLES      = TICK_NS / CLOCK_NS;
    localparam logic [7:0]  TICK_LAST        = 8'(TICK_CYCLES - 1);
    // Synchroniser reset constant, all zeros; not used by the logic
    localparam logic [1:0]  SYNC_RESET       = 2'h0;

    typedef enum logic [2:0]
    {
        STOPPED = 3'b001,
        RUNNING = 3'b010,
        LOCKED  = 3'b100
    } run_state_t;

    // Phase drive pair: source (high side) and sink (low side), one-hot except all sources on when braking
    typedef struct packed
    {
        logic [2:0] source;
        logic [2:0] sink;
    } phase_pair_t;

    // Six-step table for the low direction level; code is {a,b,c}
    function automatic phase_pair_t commutate(input logic [2:0] code,
                                              input logic       reverse);
        logic [2:0] c;
        phase_pair_t p;
        c = reverse ? ~code : code;
        p = '{source: 3'h0, sink: 3'h0};
        unique case (c)
            3'b101: p = '{source: 3'b010, sink: 3'b001};
            3'b100: p = '{source: 3'b100, sink: 3'b001};
            3'b110: p = '{source: 3'b100, sink: 3'b010};
            3'b010: p = '{source: 3'b001, sink: 3'b010};
            3'b011: p = '{source: 3'b001, sink: 3'b100};
            3'b001: p = '{source: 3'b010, sink: 3'b100};
            default: p = '{source: 3'h0, sink: 3'h0};
        endcase
        return p;
    endfunction : commutate
endpackage : motor_pkg

/* design/sync2.sv */
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module sync2
    import motor_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] reset_value,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed
    {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb
    begin
        next_state.first  = async_in;
        next_state.second = state.first;
    end

    // Reset loads each pin's idle level so no false request follows reset
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state <= {reset_value, reset_value};
        else
            state <= next_state;
    end

    assign sync_out = state.second;
endmodule : sync2

/* design/bldc_drive_lock_protect.sv */
// Commutation, speed lock and lock protection for a brushless drive
// How it works
// - Running unlocked too long turns sinks off
// - Lock interval is 52 s per microfarad
// - Trip holds until stop or power cycle
// - Grounded timer input disables lock protection
// - Lock flag low within 6.25 percent band
// - Run input low runs, high stops
// - Direction high selects reverse rotation
// - Hall pair high when positive exceeds negative
// - Discriminator high accelerates, low decelerates
// - Over-current after reversal kills sink
// - Reversal over-current shorts brake high side
// - Initial reset from tachometer input capacitor
// - Discriminator updates every two tach periods
// - Phase error updates every tach period
// - Target tach period is 8192 clocks
// - Current limit reduces PWM on duty
`timescale 1ns/1ps
module bldc_drive_lock_protect
    import motor_pkg::*;
#(
    // Lock interval in microseconds per microfarad of capacitance
    parameter int unsigned US_PER_UF = SECONDS_PER_UF * 1000000
)
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        tach_reset_n,
    input  wire logic        hall_a_pos,
    input  wire logic        hall_a_neg,
    input  wire logic        hall_b_pos,
    input  wire logic        hall_b_neg,
    input  wire logic        hall_c_pos,
    input  wire logic        hall_c_neg,
    input  wire logic        tach_pulse,
    input  wire logic        run_stop,
    input  wire logic        direction,
    input  wire logic        over_current,
    input  wire logic        pwm_on,
    input  wire logic [15:0] lock_timer_cap,
    output logic      [2:0]  phase_source,
    output logic      [2:0]  phase_sink,
    output logic             brake,
    output logic             speed_lock_flag,
    output logic             speed_lock_flag_oe,
    output logic             disc_out,
    output logic             disc_update,
    output logic             phase_err_out,
    output logic             phase_update,
    output logic             protect_tripped
);
    typedef struct packed
    {
        run_state_t  run;
        logic [13:0] period;
        logic [13:0] measured;
        logic        half;
        logic        tach_d;
        logic        last_dir;
        logic        reversed;
        logic        rev_fault;
        logic        in_lock;
        logic        disc;
        logic        disc_pulse;
        logic        phase_err;
        logic        phase_pulse;
        logic [7:0]  prescale;
        logic [47:0] lock_count;
        phase_pair_t drive;
        logic        brake;
    } core_state_t;

    core_state_t state;
    core_state_t next_state;

    logic [8:0] pins;
    logic [8:0] pins_sync;
    logic       hall_a;
    logic       hall_b;
    logic       hall_c;
    logic       tach_s;
    logic       stop_req;
    logic       dir_rev;
    logic       oc_s;
    logic       pwm_s;
    logic       init_n;
    logic       protect_on;
    logic [47:0] lock_limit;
    phase_pair_t table_pair;

    assign pins = {tach_reset_n, pwm_on, over_current, direction, run_stop,
                   tach_pulse, hall_c_pos > hall_c_neg,
                   hall_b_pos > hall_b_neg, hall_a_pos > hall_a_neg};

    // Idle levels: init released, run pin stopped, direction reverse
    sync2 #(.WIDTH(9)) pin_sync
    (
        .clock       (clock),
        .rst_n       (rst_n),
        .reset_value (9'h130),
        .async_in    (pins),
        .sync_out    (pins_sync)
    );

    assign {init_n, pwm_s, oc_s, dir_rev, stop_req, tach_s,
            hall_c, hall_b, hall_a} = pins_sync;

    // Interval scales with capacitance in microsecond ticks
    assign lock_limit = 48'(lock_timer_cap) * 48'(US_PER_UF);
    assign protect_on = (lock_timer_cap != 16'h0000);
    assign table_pair = commutate({hall_a, hall_b, hall_c}, dir_rev);

    always_comb
    begin
        next_state = state;
        next_state.disc_pulse = 1'b0;
        next_state.phase_pulse = 1'b0;
        next_state.tach_d = tach_s;
        next_state.last_dir = dir_rev;
        next_state.period = (state.period == 14'h3fff) ? state.period
                                                       : state.period + 14'h1;
        next_state.prescale = (state.prescale == TICK_LAST) ? 8'h00
                                                : state.prescale + 8'h01;
        if (tach_s && !state.tach_d)
        begin
            next_state.measured = state.period;
            // Restart at one so the latched count equals the period
            next_state.period = 14'h1;
            next_state.half = !state.half;
            next_state.phase_err = (state.period > SERVO_COUNT);
            next_state.phase_pulse = 1'b1;
            if (state.half)
            begin
                next_state.disc = (state.period > SERVO_COUNT);
                next_state.disc_pulse = 1'b1;
            end
        end
        // Band of 6.25 percent around target
        next_state.in_lock = (state.measured >= SERVO_COUNT - LOCK_BAND)
                          && (state.measured <= SERVO_COUNT + LOCK_BAND);
        if (dir_rev != state.last_dir)
            next_state.reversed = 1'b1;
        if (state.reversed && oc_s)
            next_state.rev_fault = 1'b1;
        unique case (state.run)
            STOPPED:
            begin
                next_state.lock_count = 48'h0;
                next_state.reversed = 1'b0;
                next_state.rev_fault = 1'b0;
                if (!stop_req)
                    next_state.run = RUNNING;
            end
            RUNNING:
            begin
                if (state.in_lock)
                    next_state.lock_count = 48'h0;
                else if (state.prescale == TICK_LAST)
                    next_state.lock_count = state.lock_count + 48'h1;
                // A new reversal wins over the clear
                if (state.in_lock && !oc_s && dir_rev == state.last_dir)
                    next_state.reversed = 1'b0;
                if (stop_req)
                    next_state.run = STOPPED;
                else if (protect_on && !state.in_lock
                         && state.lock_count >= lock_limit)
                    next_state.run = LOCKED;
            end
            LOCKED:
            begin
                if (stop_req)
                    next_state.run = STOPPED;
            end
            default: next_state.run = STOPPED;
        endcase
        next_state.drive = '{source: 3'h0, sink: 3'h0};
        next_state.brake = 1'b0;
        // Outputs follow the new run state so a trip kills drive at once
        if (next_state.run == RUNNING)
        begin
            if (state.rev_fault)
            begin
                // All three high sides short the windings
                next_state.drive.source = 3'b111;
                next_state.brake = 1'b1;
            end
            else
            begin
                next_state.drive.source = table_pair.source;
                // Limit chops the sink on time
                next_state.drive.sink = (pwm_s && !oc_s) ? table_pair.sink
                                                          : 3'h0;
            end
        end
    end

    // Tach capacitor reset joins the logic reset
    always_ff @(posedge clock)
    begin
        if (!rst_n || !init_n)
        begin
            state <= '0;
            state.run <= STOPPED;
        end
        else
            state <= next_state;
    end

    assign phase_source       = state.drive.source;
    assign phase_sink         = state.drive.sink;
    assign brake              = state.brake;
    assign speed_lock_flag    = 1'b0;
    assign speed_lock_flag_oe = state.in_lock;
    assign disc_out           = state.disc;
    assign disc_update        = state.disc_pulse;
    assign phase_err_out      = state.phase_err;
    assign phase_update       = state.phase_pulse;
    assign protect_tripped    = (state.run == LOCKED);
endmodule : bldc_drive_lock_protect

/* sim/bldc_drive_lock_protect_asserts.sv */
// Port checks for the brushless drive logic
`timescale 1ns/1ps
module drive_checker
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        tach_pulse,
    input wire logic        run_stop,
    input wire logic [15:0] lock_timer_cap,
    input wire logic [2:0]  phase_source,
    input wire logic [2:0]  phase_sink,
    input wire logic        brake,
    input wire logic        speed_lock_flag,
    input wire logic        phase_update,
    input wire logic        disc_out,
    input wire logic        disc_update,
    input wire logic        phase_err_out,
    input wire logic        protect_tripped
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    stop_off_a: assert property ($past(run_stop, 3) |->
        {phase_source, phase_sink, brake, protect_tripped} == 8'h0)
        else $error("drive live while stopped");
    hold_trip_a: assert property (protect_tripped &&
        !$past(run_stop, 2) |=> protect_tripped)
        else $error("trip released while running");
    trip_sink_a: assert property (protect_tripped |->
        phase_sink == 3'h0) else $error("sink on after trip");
    no_guard_a: assert property ($rose(protect_tripped) |->
        lock_timer_cap != 16'h0) else $error("trip with timer off");
    flag_low_a: assert property (speed_lock_flag == 1'b0)
        else $error("lock flag driven high");
    brake_sink_a: assert property (brake |-> phase_sink == 3'h0)
        else $error("sink on while braking");
    pair_apart_a: assert property ((phase_source & phase_sink)
        == 3'h0) else $error("source and sink on same phase");
    tach_phase_a: assert property ($rose(tach_pulse) |->
        ##3 phase_update) else $error("no phase update");
    disc_on_tach_a: assert property (disc_update |->
        phase_update) else $error("discriminator off tach edge");
    disc_sense_a: assert property (disc_update |->
        disc_out == phase_err_out) else $error("discriminator sense");
endmodule : drive_checker
bind bldc_drive_lock_protect drive_checker chk (.clock, .rst_n,
    .tach_pulse, .run_stop, .lock_timer_cap, .phase_source,
    .phase_sink, .brake, .speed_lock_flag, .phase_update,
    .disc_out, .disc_update, .phase_err_out, .protect_tripped);

/* sim/motor_sensors.sv */
// Hall sensor and tachometer model for the drive bench
`timescale 1ns/1ps
module motor_sensors
(
    input  wire logic        clock,
    input  wire logic [2:0]  hall_code,
    input  wire logic [15:0] tach_period,
    output logic      [2:0]  hall_pos,
    output logic      [2:0]  hall_neg,
    output logic             tach_pulse
);
    logic [15:0] count = 16'h0;
    initial tach_pulse = 1'b0;
    // pair high when pos above neg
    assign hall_pos = hall_code;
    assign hall_neg = ~hall_code;
    // period near 8192, still when zero
    always @(posedge clock)
    begin
        if (tach_period == 16'h0 || count >= tach_period - 16'h1)
            count <= 16'h0;
        else
            count <= count + 16'h1;
        tach_pulse <= #1 tach_period != 16'h0 && count < tach_period / 2;
    end
endmodule : motor_sensors

/* sim/bldc_drive_lock_protect_test.sv */
// Self-checking bench for the brushless drive logic
`timescale 1ns/1ps
module bldc_drive_lock_protect_test;
    logic        clock = 1'b0, rst_n = 1'b0, run_stop = 1'b1;
    logic        direction = 1'b1, over_current = 1'b0, pwm = 1'b1;
    logic [2:0]  hall_code = 3'h5, hpos, hneg, source, sink;
    logic [15:0] cap = 16'h0, period = 16'h0;
    logic        brake, tach, flag, flag_oe, disc, tripped;
    logic [19:0] notes[$];
    int          n_fail = 0, compares = 0;
    event        sample_ev;
    motor_sensors motor (.clock, .hall_code, .tach_period(period),
        .hall_pos(hpos), .hall_neg(hneg), .tach_pulse(tach));
    bldc_drive_lock_protect #(.US_PER_UF(10)) dut (.clock, .rst_n,
        .tach_reset_n(rst_n), .hall_a_pos(hpos[2]), .hall_a_neg(hneg[2]),
        .hall_b_pos(hpos[1]), .hall_b_neg(hneg[1]), .hall_c_pos(hpos[0]),
        .hall_c_neg(hneg[0]), .tach_pulse(tach), .run_stop, .direction,
        .over_current, .pwm_on(pwm), .lock_timer_cap(cap),
        .phase_source(source), .phase_sink(sink), .brake,
        .speed_lock_flag(flag), .speed_lock_flag_oe(flag_oe),
        .disc_out(disc), .disc_update(), .phase_err_out(),
        .phase_update(), .protect_tripped(tripped));
    initial forever #2 clock = ~clock;
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    // high direction level inverts the code
    function automatic logic [5:0] pair(input logic [2:0] c, logic d);
        case (d ? ~c : c)
            3'h5: return 6'h11;
            3'h4: return 6'h21;
            3'h6: return 6'h22;
            3'h2: return 6'h0a;
            3'h3: return 6'h0c;
            3'h1: return 6'h14;
            default: return 6'h00;
        endcase
    endfunction : pair
    task automatic check(input logic [9:0] v, m, input int n);
        notes.push_back({m, v});
        cyc(n);
        -> sample_ev;
    endtask : check
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    initial forever
    begin
        @(sample_ev);
        compares++;
        if (({source, sink, brake, tripped, flag_oe, disc} & notes[0][19:10])
            !== (notes[0][9:0] & notes[0][19:10]))
        begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time,
                {source, sink, brake, tripped, flag_oe, disc}, notes[0]);
        end
        void'(notes.pop_front());
    end
    initial
    begin
        cyc(95000);
        n_fail++;
        finish_test();
    end
    initial
    begin
        void'($urandom(32'he0a70b2a));
        cyc(3);
        rst_n = 1'b1;
        check(10'h000, 10'h3fc, 3);
        run_stop = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            hall_code = i[2:0];
            direction = i[3];
            check({pair(i[2:0], i[3]), 4'h0}, 10'h3fc, 3);
        end
        run_stop = 1'b1;
        check(10'h000, 10'h3fc, 3);
        done("commutation");
        // reversal only with the rotor at rest
        hall_code = 3'h5;
        direction = 1'b0;
        run_stop = 1'b0;
        cyc(5);
        direction = 1'b1;
        over_current = 1'b1;
        check(10'h388, 10'h3fc, 6);
        over_current = 1'b0;
        check(10'h388, 10'h3fc, 6);
        run_stop = 1'b1;
        check(10'h000, 10'h3fc, 3);
        run_stop = 1'b0;
        over_current = 1'b1;
        check(10'h080, 10'h3fc, 6);
        over_current = 1'b0;
        pwm = 1'b0;
        check(10'h080, 10'h3fc, 3);
        pwm = 1'b1;
        done("reversal");
        cap = 16'h1;
        cyc(1800);
        run_stop = 1'b1;
        cyc(10);
        run_stop = 1'b0;
        check(10'h000, 10'h004, 2200);
        check(10'h004, 10'h074, 400);
        direction = 1'b0;
        check(10'h004, 10'h074, 100);
        run_stop = 1'b1;
        check(10'h000, 10'h004, 3);
        cap = 16'h0;
        run_stop = 1'b0;
        check(10'h000, 10'h004, 3000);
        done("lock");
        for (int k = 0; k < 3; k++)
        begin
            case (k)
                0: period = 16'h2000 + 16'h264 + 16'($urandom % 200);
                1: period = 16'h2000 - 16'h264 - 16'($urandom % 200);
                default: period = 16'h1e70 + 16'($urandom % 800);
            endcase
            check(k == 2 ? 10'h002 : {9'h0, k == 0},
                k == 2 ? 10'h002 : 10'h003, 3 * period + 20);
        end
        period = 16'h0;
        done("speed");
        finish_test();
    end
endmodule : bldc_drive_lock_protect_test
